/* urx_pkg.sv */
// How it works
// - Idle receiver watches the serial input for a high-to-low edge, then times bits.
// - Start bit kept only if input still low at its centre sample, else dropped.
// - Data bits per character come from the two low line-control bits.
// - Line-control bits 3 and 4 choose parity enable and even/odd polarity.
// - Data-ready status bit 0 sets once a full character with stop arrives.
// - Without FIFO, reading the receive holding register clears data ready.
// - New character landing before the previous one was read (in FIFO mode: into a full FIFO) sets overrun, bit 1.
// - Wrong received parity sets the parity error status, bit 2.
// - Missing stop bit sets the framing error status, bit 3.
// - In FIFO mode each character is stored with its parity, framing, break bits.
// - Start edge is seen within one 16x sampling period of the true edge.
// - 16x sampling lands within a few percent of bit centre, 43.75% margin.
// - With auto-CTS on, the transmitter may only send while CTS is asserted.
// - With auto-RTS and FIFO mode on, RTS is active while the receiver can take more data.
// - RTS to CTS with autoflow both ends: sender sends only while FIFO has room.
// - Baud generator gives sixteen ticks per bit: clock divided by divisor.
package urx_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_LCR = 8'h04;
  localparam logic [7:0] OFS_LSR = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_ISR = 8'h14;
  localparam logic [7:0] OFS_IMR = 8'h18;
  // Line control fields
  localparam int unsigned LCR_LEN_LO = 0;
  localparam int unsigned LCR_PAR_EN = 3;
  localparam int unsigned LCR_EVEN = 4;
  // Line status / interrupt status fields (same layout)
  localparam int unsigned ST_DR = 0;
  localparam int unsigned ST_OE = 1;
  localparam int unsigned ST_PE = 2;
  localparam int unsigned ST_FE = 3;
  localparam int unsigned ST_BI = 4;
  localparam int unsigned ST_W = 5;
  // Control fields
  localparam int unsigned CTL_FIFO = 0;
  localparam int unsigned CTL_ARTS = 1;
  localparam int unsigned CTL_ACTS = 2;
  localparam int unsigned CTL_W = 3;
  // Timing in 16x ticks
  localparam logic [3:0] TICK_CENTRE = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] BASE_BITS = 4'h5;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // Receive FIFO: data plus parity, framing, break
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned ENT_W = 11;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    URX_IDLE = 3'b000,
    URX_START = 3'b001,
    URX_DATA = 3'b011,
    URX_PAR = 3'b010,
    URX_STOP = 3'b110
  } urx_state_t;
endpackage

/* urx_receiver.sv */
`timescale 1ns/10ps
`default_nettype none
module urx_receiver (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [urx_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_input,
  input wire logic cts_n,
  output logic tx_allowed,
  output logic rts_n,
  output logic irq
);
  import urx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] line_control_reg_ff;
  logic [15:0] div_ff;
  logic [CTL_W-1:0] ctrl_ff;
  logic [ST_W-1:0] lsr_ff;
  logic [ST_W-1:0] isr_ff;
  logic [ST_W-1:0] imr_ff;
  logic [7:0] receive_holding_reg_ff;
  logic [ENT_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W:0] wr_ptr_ff;
  logic [PTR_W:0] rd_ptr_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] baud_cnt_ff;
  logic tick;
  urx_state_t state_ff;
  logic [3:0] tcnt_ff;
  logic [3:0] bit_ff;
  logic [7:0] receive_shift_reg_ff;
  logic par_acc_ff;
  logic par_err_ff;
  logic rx_prev_ff;
  logic char_done;
  logic [ST_W-1:0] ev;
  logic fifo_mode;
  logic fifo_full;
  logic fifo_empty;
  logic [PTR_W:0] fifo_cnt;
  logic addr_ok;
  logic rd_data;
  logic rd_lsr;
  logic [3:0] n_bits;
  logic brk;
  logic stop_bad;
  logic [ENT_W-1:0] head;

  assign fifo_mode = ctrl_ff[CTL_FIFO];
  assign fifo_cnt = wr_ptr_ff - rd_ptr_ff;
  assign fifo_empty = (wr_ptr_ff == rd_ptr_ff);
  assign fifo_full = (fifo_cnt == (PTR_W+1)'(FIFO_DEPTH));
  assign head = fifo_mem[rd_ptr_ff[PTR_W-1:0]];
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_data = addr_ok && !hwrite && (haddr == OFS_DATA);
  assign rd_lsr = addr_ok && !hwrite && (haddr == OFS_LSR);
  assign n_bits = BASE_BITS + {2'b00, line_control_reg_ff[LCR_LEN_LO+:2]};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, side effects taken at the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr)
        // FIFO mode shows the head entry's error bits above its data byte
        OFS_DATA: hrdata_ff <= fifo_mode ? {21'h00000, head}
                                         : {24'h000000, receive_holding_reg_ff};
        OFS_LCR: hrdata_ff <= {24'h000000, line_control_reg_ff};
        OFS_LSR: hrdata_ff <= {27'h0000000, lsr_ff[ST_W-1:1],
                               fifo_mode ? !fifo_empty : lsr_ff[ST_DR]};
        OFS_DIV: hrdata_ff <= {16'h0000, div_ff};
        OFS_CTRL: hrdata_ff <= {29'h00000000, ctrl_ff};
        OFS_ISR: hrdata_ff <= {27'h0000000, isr_ff};
        OFS_IMR: hrdata_ff <= {27'h0000000, imr_ff};
        default: hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_control_reg_ff <= 8'h00;
      div_ff <= DIV_RST;
      ctrl_ff <= '0;
      imr_ff <= '0;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == OFS_LCR) line_control_reg_ff <= hwdata[7:0];
      if (wr_addr_ff == OFS_DIV) div_ff <= hwdata[15:0];
      if (wr_addr_ff == OFS_CTRL) ctrl_ff <= hwdata[CTL_W-1:0];
      if (wr_addr_ff == OFS_IMR) imr_ff <= hwdata[ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator; reloads on a divisor write so a new rate takes at once
  always_ff @(posedge core_clk) begin
    if (sys_rst || (wr_pend_ff && wr_addr_ff == OFS_DIV)) begin
      baud_cnt_ff <= 16'h0000;
    end else if (baud_cnt_ff + 16'h0001 >= div_ff) begin
      baud_cnt_ff <= 16'h0000;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + 16'h0001;
    end
  end
  // Divisor zero stops the receiver clock
  assign tick = (div_ff != 16'h0000) && (baud_cnt_ff + 16'h0001 >= div_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Receiver sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= serial_input;
    end
  end

  assign brk = (receive_shift_reg_ff == 8'h00) && !serial_input;
  assign stop_bad = !serial_input;
  assign char_done = tick && (state_ff == URX_STOP) && (tcnt_ff == TICK_LAST);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= URX_IDLE;
      tcnt_ff <= 4'h0;
      bit_ff <= 4'h0;
      receive_shift_reg_ff <= 8'h00;
      par_acc_ff <= 1'b0;
      par_err_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        URX_IDLE: begin
          // Edge is caught at core clock rate, within one tick
          if (rx_prev_ff && !serial_input) begin
            state_ff <= URX_START;
            tcnt_ff <= 4'h0;
          end
        end
        URX_START: begin
          if (tick) begin
            if (tcnt_ff == TICK_CENTRE) begin
              if (serial_input) begin
                state_ff <= URX_IDLE;
              end else begin
                state_ff <= URX_DATA;
                tcnt_ff <= 4'h0;
                bit_ff <= 4'h0;
                receive_shift_reg_ff <= 8'h00;
                par_acc_ff <= 1'b0;
              end
            end else begin
              tcnt_ff <= tcnt_ff + 4'h1;
            end
          end
        end
        URX_DATA: begin
          if (tick) begin
            tcnt_ff <= tcnt_ff + 4'h1;
            if (tcnt_ff == TICK_LAST) begin
              receive_shift_reg_ff[bit_ff[2:0]] <= serial_input;
              par_acc_ff <= par_acc_ff ^ serial_input;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff + 4'h1 == n_bits) begin
                state_ff <= line_control_reg_ff[LCR_PAR_EN] ? URX_PAR : URX_STOP;
              end
            end
          end
        end
        URX_PAR: begin
          if (tick) begin
            tcnt_ff <= tcnt_ff + 4'h1;
            if (tcnt_ff == TICK_LAST) begin
              // Even parity: total ones even; odd: total ones odd
              par_err_ff <= (par_acc_ff ^ serial_input) == line_control_reg_ff[LCR_EVEN];
              state_ff <= URX_STOP;
            end
          end
        end
        URX_STOP: begin
          if (tick) begin
            tcnt_ff <= tcnt_ff + 4'h1;
            if (tcnt_ff == TICK_LAST) begin
              state_ff <= URX_IDLE;
              par_err_ff <= 1'b0;
            end
          end
        end
        default: state_ff <= URX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character store: holding register or FIFO
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      receive_holding_reg_ff <= 8'h00;
    end else if (char_done && !fifo_mode) begin
      receive_holding_reg_ff <= receive_shift_reg_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (char_done && fifo_mode && !fifo_full) begin
      fifo_mem[wr_ptr_ff[PTR_W-1:0]] <= {brk, stop_bad, par_err_ff, receive_shift_reg_ff};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !fifo_mode) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      // A full FIFO drops the new character and flags overrun
      if (char_done && !fifo_full) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (rd_data && !fifo_empty) rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: events win over a clear in the same cycle
  always_comb begin
    ev = '0;
    ev[ST_DR] = char_done;
    ev[ST_OE] = char_done && (fifo_mode ? fifo_full : lsr_ff[ST_DR]);
    ev[ST_PE] = char_done && par_err_ff;
    ev[ST_FE] = char_done && stop_bad;
    ev[ST_BI] = char_done && brk;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lsr_ff <= '0;
    end else begin
      // Data ready clears on a holding read; error bits clear on a status read
      lsr_ff[ST_DR] <= ev[ST_DR] || (lsr_ff[ST_DR] && !rd_data);
      lsr_ff[ST_W-1:1] <= ev[ST_W-1:1] | (lsr_ff[ST_W-1:1] & {(ST_W-1){!rd_lsr}});
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      isr_ff <= '0;
    end else if (wr_pend_ff && wr_addr_ff == OFS_ISR) begin
      isr_ff <= ev | (isr_ff & ~hwdata[ST_W-1:0]);
    end else begin
      isr_ff <= ev | isr_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(isr_ff & imr_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Autoflow. RTS drops one slot early while a character is in flight,
  // since the sender may already be committed to it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rts_n <= 1'b1;
    end else if (!(ctrl_ff[CTL_ARTS] && fifo_mode)) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= !(fifo_cnt < (PTR_W+1)'(FIFO_DEPTH - 1) ||
                 (!fifo_full && state_ff == URX_IDLE));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_allowed <= 1'b0;
    end else begin
      tx_allowed <= !ctrl_ff[CTL_ACTS] || !cts_n;
    end
  end

endmodule
`default_nettype wire

/* urx_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module urx_peer (
  input wire logic core_clk,
  input wire logic rts_n,
  output logic serial_input
);
  int bit_cyc = 16;
  // Counts frames sent after giving up on the flow-control wait
  int stall_n = 0;
  initial serial_input = 1'b1;
  task automatic bitout(input logic b, input int c);
    serial_input <= b;
    repeat (c) @(posedge core_clk);
  endtask
  // Frame goes out LSB first; a low stop is followed by one idle bit
  task automatic send(input logic [7:0] d, input int n, input logic [1:0] pb,
                      input logic st, input logic fl);
    int i;
    for (i = 0; i < 900 && fl && rts_n !== 1'b0; i++) @(posedge core_clk);
    if (fl && i == 900) stall_n++;
    bitout(1'b0, bit_cyc);
    for (i = 0; i < n; i++) bitout(d[i], bit_cyc);
    if (pb[1]) bitout(pb[0], bit_cyc);
    bitout(st, bit_cyc);
    if (!st) bitout(1'b1, bit_cyc);
  endtask
endmodule
`default_nettype wire

/* urx_receiver_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module urx_receiver_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [urx_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic cts_n,
  input wire logic tx_allowed,
  input wire logic rts_n,
  input wire logic irq
);
  import urx_pkg::*;
  logic rd_take;
  assign rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  ////////////////////////////////////////////////////////////////////////////
  never_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst) hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (@(posedge core_clk) disable iff (sys_rst) !hresp)
    else $error("hresp not okay");
  rst_flow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(sys_rst) |-> rts_n && !irq)
    else $error("rts_n or irq wrong after reset");
  rst_tx_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(sys_rst) |-> !tx_allowed)
    else $error("tx_allowed high after reset");
  rdata_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !rd_take |=> $stable(hrdata))
    else $error("hrdata moved without read");
  cts_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cts_n && !$past(sys_rst) |=> tx_allowed)
    else $error("tx blocked with cts asserted");
  unmap_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_take && haddr == 8'h20 |-> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_take |-> ##1 hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule
bind urx_receiver urx_receiver_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cts_n(cts_n),
  .tx_allowed(tx_allowed), .rts_n(rts_n), .irq(irq));
`default_nettype wire

/* urx_receiver_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module urx_receiver_tb_top;
  import urx_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic cts_n = 1'b1;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, tx_allowed, rts_n, irq, serial_input;
  int fail_count = 0;
  int n_checks = 0;
  always #5 core_clk = ~core_clk;
  urx_peer u_peer (.core_clk(core_clk), .rts_n(rts_n), .serial_input(serial_input));
  urx_receiver u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_input(serial_input),
    .cts_n(cts_n), .tx_allowed(tx_allowed), .rts_n(rts_n), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic hwait();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) begin
      chk("hready", 32'h0, 32'h1);
      conclude();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk(nm, v, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_len();
    logic [7:0] m;
    for (int l = 0; l < 4; l++) begin
      m = 8'hFF >> (3 - l);
      wr(OFS_LCR, l);
      u_peer.send(8'hB6, 5 + l, 2'h0, 1'b1, 1'b0);
      settle();
      rdc(OFS_LSR, 32'h1, "lsr");
      rdc(OFS_DATA, {24'h0, 8'hB6 & m}, "data");
      rdc(OFS_LSR, 32'h0, "lsr");
    end
  endtask
  task automatic t_par();
    logic ev, bad;
    for (int k = 0; k < 4; k++) begin
      ev = k[0];
      bad = k[1];
      wr(OFS_LCR, {27'h0, ev, 4'hB});
      u_peer.send(8'h3D, 8, {1'b1, (^8'h3D) ^ !ev ^ bad}, 1'b1, 1'b0);
      settle();
      rdc(OFS_LSR, {29'h0, bad, 2'h1}, "lsr par");
      rdc(OFS_DATA, 32'h3D, "data");
    end
  endtask
  task automatic t_frm_ovr();
    wr(OFS_LCR, 32'h3);
    u_peer.send(8'h55, 8, 2'h0, 1'b0, 1'b0);
    settle();
    rdc(OFS_LSR, 32'h9, "lsr frm");
    rdc(OFS_DATA, 32'h55, "data");
    u_peer.send(8'h00, 8, 2'h0, 1'b0, 1'b0);
    settle();
    rdc(OFS_LSR, 32'h19, "lsr brk");
    rdc(OFS_DATA, 32'h0, "data brk");
    u_peer.send(8'hA1, 8, 2'h0, 1'b1, 1'b0);
    u_peer.send(8'h5E, 8, 2'h0, 1'b1, 1'b0);
    settle();
    rdc(OFS_LSR, 32'h3, "lsr ovr");
    rdc(OFS_DATA, 32'h5E, "data");
    // Glitch shorter than half a bit must be dropped
    u_peer.bitout(1'b0, 5);
    u_peer.bitout(1'b1, 200);
    rdc(OFS_LSR, 32'h0, "lsr noise");
  endtask
  task automatic t_irq();
    wr(OFS_IMR, 32'h1);
    wr(OFS_ISR, 32'h1F);
    settle();
    chk("irq", irq, 32'h0);
    u_peer.send(8'h42, 8, 2'h0, 1'b1, 1'b0);
    settle();
    chk("irq", irq, 32'h1);
    wr(OFS_IMR, 32'h0);
    settle();
    chk("irq", irq, 32'h0);
    wr(OFS_IMR, 32'h1);
    settle();
    chk("irq", irq, 32'h1);
    wr(OFS_ISR, 32'h1);
    settle();
    chk("irq", irq, 32'h0);
    rdc(OFS_DATA, 32'h42, "data");
  endtask
  task automatic t_fifo();
    wr(OFS_CTRL, 32'h3);
    settle();
    chk("rts_n", rts_n, 32'h0);
    for (int i = 1; i <= 16; i++) u_peer.send(i, 8, 2'h0, i != 16, 1'b1);
    settle();
    chk("flow stall", u_peer.stall_n, 32'h0);
    chk("rts_n", rts_n, 32'h1);
    rdc(OFS_LSR, 32'h9, "lsr fifo");
    rdc(OFS_DATA, 32'h1, "fifo");
    settle();
    chk("rts_n", rts_n, 32'h0);
    for (int i = 2; i <= 16; i++) rdc(OFS_DATA, (i == 16) ? 32'h210 : i, "fifo");
    rdc(OFS_LSR, 32'h0, "lsr");
    wr(OFS_CTRL, 32'h4);
    settle();
    chk("tx", tx_allowed, 32'h0);
    cts_n <= 1'b0;
    settle();
    chk("tx", tx_allowed, 32'h1);
    wr(OFS_CTRL, 32'h0);
  endtask
  task automatic t_div();
    wr(OFS_DIV, 32'h2);
    rdc(OFS_DIV, 32'h2, "div");
    u_peer.bit_cyc = 32;
    u_peer.send(8'h99, 8, 2'h0, 1'b1, 1'b0);
    settle();
    rdc(OFS_DATA, 32'h99, "data slow");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rdc(OFS_LSR, 32'h0, "lsr rst");
    rdc(OFS_DIV, {16'h0, DIV_RST}, "div rst");
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0, "unmapped");
    t_len();
    t_par();
    t_frm_ovr();
    t_irq();
    t_fifo();
    t_div();
    conclude();
  end
endmodule
`default_nettype wire
